/* logic/mlf_defs.svh */
// Purpose: Offsets, fields, reset values and timing counts for lock config
// Assumes: 250 MHz core clock
// Notes:   Definitions only
`ifndef MLF_DEFS_SVH
`define MLF_DEFS_SVH

// ****************************************
// Register offsets
// ****************************************
`define MLF_OFS_SET_ONE     8'h90   // First fault settings register
`define MLF_OFS_SET_TWO     8'h94   // Second fault settings register
`define MLF_OFS_STATUS      8'hA0   // Sticky event status, write one to clear
`define MLF_OFS_MASK        8'hA4   // Interrupt mask
`define MLF_OFS_STATE       8'hA8   // Live block state
`define MLF_OFS_CLEAR       8'hAC   // Fault clear command

// ****************************************
// Field positions and reset values
// ****************************************
`define MLF_RESP_HI         6       // Response field top bit
`define MLF_RESP_LO         3       // Response field bottom bit
`define MLF_RETRY_HI        2       // Retry delay field top bit
`define MLF_RETRY_LO        0       // Retry delay field bottom bit
`define MLF_ABN_EN_BIT      30      // Abnormal speed detector enable
`define MLF_SYNC_EN_BIT     29      // Sync loss detector enable
`define MLF_NOMTR_EN_BIT    28      // No motor detector enable
`define MLF_RST_SET_ONE     32'h0000_0000
`define MLF_RST_SET_TWO     32'h0000_0000

// ****************************************
// Response codes
// ****************************************
`define MLF_RESP_LATCH_MAX  4'h3    // Last latched response
`define MLF_RESP_RETRY_MAX  4'h7    // Last auto retry response
`define MLF_RESP_REPORT     4'h8    // Report only
`define MLF_RESP_SPARE      4'hA    // Undescribed code, treated as report

// ****************************************
// Retry delays in ms and cycles per ms
// ****************************************
`define MLF_CLK_MHZ         250
`define MLF_CYC_PER_MS      (`MLF_CLK_MHZ * 1000)
`define MLF_T0_MS           100
`define MLF_T1_MS           500
`define MLF_T2_MS           1000
`define MLF_T3_MS           2000
`define MLF_T4_MS           3000
`define MLF_T5_MS           5000
`define MLF_T6_MS           7500
`define MLF_T7_MS           10000

`endif

/* logic/mlf_pkg.sv */
// Purpose: Types shared by the lock fault block
// Assumes: Nothing
// Notes:   Constants live in mlf_defs.svh
package mlf_pkg;

   // Output stage command
   typedef enum logic [2:0] {
      STAGE_RUN,
      STAGE_TRISTATE,
      STAGE_RECIRC,
      STAGE_HS_BRAKE,
      STAGE_LS_BRAKE
   } mlf_stage_type;

   // Register bus request
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } mlf_bus_type;

   // Detector event flags
   typedef struct packed {
      logic abnSpeed;
      logic syncLoss;
      logic noMotor;
   } mlf_lock_type;

endpackage

/* logic/mlf_retry_timer.sv */
// Purpose: Counts the lock retry delay
// Assumes: Start is a pulse; selection held steady while running
// Notes:   Scale divides the ms tick for fast simulation
`timescale 1ns/1ps
`include "mlf_defs.svh"
module mlf_retry_timer #(
   parameter int CYC_PER_MS = `MLF_CYC_PER_MS
) (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst_b,
   // Control
   input  wire logic       start,
   input  wire logic [2:0] delaySel,
   // Status
   output logic            done
);

   logic [31:0] tickCnt_r, tickCnt_nxt;   // Cycles inside one ms
   logic [13:0] msCnt_r, msCnt_nxt;       // Elapsed ms
   logic        run_r, run_nxt;           // Timer running
   logic        done_r, done_nxt;         // Expiry pulse

   // Map selection to ms
   function automatic logic [13:0] delayMs(input logic [2:0] sel);
      case (sel)
         3'h0:    delayMs = 14'(`MLF_T0_MS);
         3'h1:    delayMs = 14'(`MLF_T1_MS);
         3'h2:    delayMs = 14'(`MLF_T2_MS);
         3'h3:    delayMs = 14'(`MLF_T3_MS);
         3'h4:    delayMs = 14'(`MLF_T4_MS);
         3'h5:    delayMs = 14'(`MLF_T5_MS);
         3'h6:    delayMs = 14'(`MLF_T6_MS);
         default: delayMs = 14'(`MLF_T7_MS);
      endcase
   endfunction

   // Next state of the counter
   always_comb begin
      tickCnt_nxt = tickCnt_r;
      msCnt_nxt   = msCnt_r;
      run_nxt     = run_r;
      done_nxt    = 1'b0;
      if (start) begin
         tickCnt_nxt = 32'h0;
         msCnt_nxt   = 14'h0;
         run_nxt     = 1'b1;
      end else if (run_r) begin
         if (tickCnt_r == 32'(CYC_PER_MS - 1)) begin
            tickCnt_nxt = 32'h0;
            if (msCnt_r == delayMs(delaySel) - 14'h1) begin
               run_nxt  = 1'b0;
               done_nxt = 1'b1;
            end else begin
               msCnt_nxt = msCnt_r + 14'h1;
            end
         end else begin
            tickCnt_nxt = tickCnt_r + 32'h1;
         end
      end
   end

   // Register the counter
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         tickCnt_r <= 32'h0;
         msCnt_r   <= 14'h0;
         run_r     <= 1'b0;
         done_r    <= 1'b0;
      end else begin
         tickCnt_r <= tickCnt_nxt;
         msCnt_r   <= msCnt_nxt;
         run_r     <= run_nxt;
         done_r    <= done_nxt;
      end
   end

   assign done = done_r;

endmodule // mlf_retry_timer

/* logic/mlf_lock_fault.sv */
// Overview of operation
// - Codes 0-3 latch fault, set stage, assert pin
// - Codes 4-7 same stage, auto retry after delay
// - Code 8 reports only, no stage action
// - Codes 9, B-F disable lock detection
// - Abnormal speed detector gated by bit 30
// - Sync loss detector gated by bit 29
// - No motor detector gated by bit 28
//
// Purpose: Motor lock fault configuration and response
// Assumes: Lock inputs are single-cycle pulses from same clock domain
// Notes:   Interrupt on sticky event status gated by mask
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`include "mlf_defs.svh"
module mlf_lock_fault #(
   parameter int CYC_PER_MS = `MLF_CYC_PER_MS
) (
   // Clock and reset
   input  wire logic                 core_clk,
   input  wire logic                 rst_b,
   // Register bus
   input  wire logic [7:0]           regAddr,
   input  wire logic [31:0]          regWdata,
   input  wire logic                 regWr,
   input  wire logic                 regRd,
   output logic [31:0]               regRdata,
   // Detector events
   input  wire mlf_pkg::mlf_lock_type lockEvt,
   // Output stage and fault pin
   output mlf_pkg::mlf_stage_type    stageCmd,
   output logic                      faultIndicatorPin_b,
   output logic                      lockReport,
   // Interrupt
   output logic                      irq
);

   // ****************************************
   // Declarations
   // ****************************************
   typedef enum {IDLE, LATCHED, RETRY} mlf_state_type;

   mlf_pkg::mlf_bus_type   bus;                      // Bundled request
   logic [31:0]            setOne_r, setOne_nxt;     // Response settings
   logic [31:0]            setTwo_r, setTwo_nxt;     // Detector enables
   logic [2:0]             status_r, status_nxt;     // Sticky events
   logic [2:0]             mask_r, mask_nxt;         // Interrupt mask
   logic [31:0]            rdata_r, rdata_nxt;       // Read data
   mlf_state_type          state_r, state_nxt;       // Response state
   mlf_pkg::mlf_stage_type stage_r, stage_nxt;       // Stage command
   logic                   fault_r, fault_nxt;       // Fault asserted
   logic                   faultPin_b_r, faultPin_b_nxt; // Fault pin flop
   logic                   report_r, report_nxt;     // Report pulse
   logic                   irq_r, irq_nxt;           // Interrupt level
   logic [3:0]             resp;                     // Response field
   logic                   lockHit;                  // Enabled lock seen
   logic                   lockActive;               // Detection active
   logic                   clearCmd;                 // Software clear
   logic                   retryStart;               // Start retry timer
   logic                   retryDone;                // Retry elapsed
   logic [2:0]             evtVec;                   // Events as bits

   assign bus = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};
   assign resp = setOne_r[`MLF_RESP_HI:`MLF_RESP_LO];
   assign clearCmd = bus.wr && bus.addr == `MLF_OFS_CLEAR && bus.wdata[0];

   // Stage for the low two bits of the response code
   function automatic mlf_pkg::mlf_stage_type stageOf(input logic [1:0] c);
      case (c)
         2'h0:    stageOf = mlf_pkg::STAGE_TRISTATE;
         2'h1:    stageOf = mlf_pkg::STAGE_RECIRC;
         2'h2:    stageOf = mlf_pkg::STAGE_HS_BRAKE;
         default: stageOf = mlf_pkg::STAGE_LS_BRAKE;
      endcase
   endfunction

   // ****************************************
   // Detector gating
   // ****************************************
   // Each detector only counts while its enable bit is set
   always_comb begin
      evtVec = 3'h0;
      evtVec[2] = lockEvt.abnSpeed & setTwo_r[`MLF_ABN_EN_BIT];
      evtVec[1] = lockEvt.syncLoss & setTwo_r[`MLF_SYNC_EN_BIT];
      evtVec[0] = lockEvt.noMotor & setTwo_r[`MLF_NOMTR_EN_BIT];
   end

   // Code 9 and B-F switch detection off; A left undescribed, kept on
   assign lockActive = (resp <= `MLF_RESP_REPORT) ||
                       (resp == `MLF_RESP_SPARE);
   assign lockHit = lockActive && (|evtVec);

   // ****************************************
   // Retry timer
   // ****************************************
   mlf_retry_timer #(
      .CYC_PER_MS (CYC_PER_MS)
   ) u_timer (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .start    (retryStart),
      .delaySel (setOne_r[`MLF_RETRY_HI:`MLF_RETRY_LO]),
      .done     (retryDone)
   );

   // ****************************************
   // Response state machine
   // ****************************************
   // Chooses stage, fault pin and retry from the response code
   always_comb begin
      state_nxt  = state_r;
      stage_nxt  = stage_r;
      fault_nxt  = fault_r;
      report_nxt = lockHit;                   // Every accepted lock reported
      retryStart = 1'b0;
      case (state_r)
         IDLE: begin
            if (lockHit) begin
               if (resp <= `MLF_RESP_LATCH_MAX) begin
                  state_nxt = LATCHED;
                  stage_nxt = stageOf(resp[1:0]);
                  fault_nxt = 1'b1;
               end else if (resp <= `MLF_RESP_RETRY_MAX) begin
                  state_nxt  = RETRY;
                  stage_nxt  = stageOf(resp[1:0]);
                  retryStart = 1'b1;
               end
               // Report-only code leaves the stage running
            end
         end
         LATCHED: begin
            // Held until software clears it
            if (clearCmd) begin
               state_nxt = IDLE;
               stage_nxt = mlf_pkg::STAGE_RUN;
               fault_nxt = 1'b0;
            end
         end
         RETRY: begin
            // Recover without software once delay ends
            if (retryDone) begin
               state_nxt = IDLE;
               stage_nxt = mlf_pkg::STAGE_RUN;
            end
         end
         default: begin
            state_nxt = IDLE;
            stage_nxt = mlf_pkg::STAGE_RUN;
            fault_nxt = 1'b0;
         end
      endcase
      // Pin is low while the fault is held, kept in its own flop
      faultPin_b_nxt = ~fault_nxt;
   end

   // Register the response state
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         state_r  <= IDLE;
         stage_r  <= mlf_pkg::STAGE_RUN;
         fault_r  <= 1'b0;
         report_r <= 1'b0;
         faultPin_b_r <= 1'b1;
      end else begin
         state_r  <= state_nxt;
         stage_r  <= stage_nxt;
         fault_r  <= fault_nxt;
         report_r <= report_nxt;
         faultPin_b_r <= faultPin_b_nxt;
      end
   end

   // ****************************************
   // Register file
   // ****************************************
   // Writes, sticky status with set winning, and read mux
   always_comb begin
      setOne_nxt = setOne_r;
      setTwo_nxt = setTwo_r;
      mask_nxt   = mask_r;
      status_nxt = status_r;
      rdata_nxt  = 32'h0;
      if (bus.wr) begin
         case (bus.addr)
            `MLF_OFS_SET_ONE: setOne_nxt = bus.wdata;
            `MLF_OFS_SET_TWO: setTwo_nxt = bus.wdata;
            `MLF_OFS_MASK:    mask_nxt   = bus.wdata[2:0];
            `MLF_OFS_STATUS:  status_nxt = status_r & ~bus.wdata[2:0];
            default:          setOne_nxt = setOne_r;
         endcase
      end
      status_nxt = status_nxt | (lockActive ? evtVec : 3'h0);
      if (bus.rd) begin
         case (bus.addr)
            `MLF_OFS_SET_ONE: rdata_nxt = setOne_r;
            `MLF_OFS_SET_TWO: rdata_nxt = setTwo_r;
            `MLF_OFS_STATUS:  rdata_nxt = {29'h0, status_r};
            `MLF_OFS_MASK:    rdata_nxt = {29'h0, mask_r};
            `MLF_OFS_STATE:   rdata_nxt = {26'h0, fault_r,
                                           state_r == RETRY,
                                           1'b0, stage_r};
            default:          rdata_nxt = 32'h0;
         endcase
      end
      irq_nxt = |(status_nxt & mask_nxt);
   end

   // Register the bank
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         setOne_r <= `MLF_RST_SET_ONE;
         setTwo_r <= `MLF_RST_SET_TWO;
         mask_r   <= 3'h0;
         status_r <= 3'h0;
         rdata_r  <= 32'h0;
         irq_r    <= 1'b0;
      end else begin
         setOne_r <= setOne_nxt;
         setTwo_r <= setTwo_nxt;
         mask_r   <= mask_nxt;
         status_r <= status_nxt;
         rdata_r  <= rdata_nxt;
         irq_r    <= irq_nxt;
      end
   end

   // Outputs straight from flops
   assign regRdata            = rdata_r;
   assign stageCmd            = stage_r;
   assign faultIndicatorPin_b = faultPin_b_r;
   assign lockReport          = report_r;
   assign irq                 = irq_r;

   // ****************************************
   // Assertions
   // ****************************************
   // Lock accepted in idle with a latching code
   sequence s_latchHit;
      lockHit && state_r == IDLE && resp <= 4'h3;
   endsequence

   // Lock accepted in idle with an auto retry code
   sequence s_retryHit;
      lockHit && state_r == IDLE && resp > 4'h3 && resp <= 4'h7;
   endsequence

   // Clear command seen while a fault is latched
   sequence s_latchClear;
      state_r == LATCHED && clearCmd;
   endsequence

   // Latching code drives the stage and the pin
   a_latch_sets_fault: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      s_latchHit |=> !faultIndicatorPin_b && stageCmd != mlf_pkg::STAGE_RUN)
      else $error("latched lock did not assert fault");

   // Retry code leaves the pin alone
   a_retry_no_fault: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      s_retryHit |=> faultIndicatorPin_b && state_r == RETRY)
      else $error("retry lock wrongly latched");

   // Retry delay end returns the stage to run
   a_retry_recovers: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      (state_r == RETRY && retryDone) |=>
      state_r == IDLE && stageCmd == mlf_pkg::STAGE_RUN)
      else $error("retry delay end did not recover");

   // Report-only code reports and leaves the stage running
   a_report_only: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      (lockHit && state_r == IDLE && resp == 4'h8) |=>
      stageCmd == mlf_pkg::STAGE_RUN && lockReport)
      else $error("report-only code acted on stage");

   // Disabled codes never report a lock
   a_disabled_quiet: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      ((resp == 4'h9 || resp >= 4'hB) && lockEvt != 3'h0) |=> !lockReport)
      else $error("disabled detection still hit");

   // Abnormal speed alone is ignored while its enable is low
   a_abn_gate: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      (!setTwo_r[`MLF_ABN_EN_BIT] && lockEvt == 3'h4) |=> !lockReport)
      else $error("abnormal speed passed while off");

   // Sync loss alone is ignored while its enable is low
   a_sync_gate: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      (!setTwo_r[`MLF_SYNC_EN_BIT] && lockEvt == 3'h2) |=> !lockReport)
      else $error("sync loss passed while off");

   // No motor alone is ignored while its enable is low
   a_nomtr_gate: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      (!setTwo_r[`MLF_NOMTR_EN_BIT] && lockEvt == 3'h1) |=> !lockReport)
      else $error("no motor passed while off");

   // Latched fault stays put until cleared
   a_latch_holds: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      (state_r == LATCHED && !clearCmd) |=>
      state_r == LATCHED && !faultIndicatorPin_b && $stable(stageCmd))
      else $error("latched fault released without clear");

   // Clear releases the pin and the stage
   a_clear_releases: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      s_latchClear |=> faultIndicatorPin_b && stageCmd == mlf_pkg::STAGE_RUN)
      else $error("clear did not release latched fault");

   // Read data stand for one cycle only
   a_read_stands: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      !regRd |=> regRdata == 32'h0)
      else $error("read data stood past its cycle");

   // Status events stay until written away
   a_status_sticky: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      (|status_r && !(regWr && regAddr == `MLF_OFS_STATUS)) |=> |status_r)
      else $error("status event lost without clear");

endmodule // mlf_lock_fault

/* testbench/mlf_stage_model.sv */
// Purpose: Detector and output stage stand-in for the lock fault block
// Assumes: One clock; the bench asks for detector pulses
// Notes:   Measures how long the stage stays out of the run state
`timescale 1ns/1ps
module mlf_stage_model (
   // Clock and reset
   input  wire logic                   core_clk,
   input  wire logic                   rst_b,
   // Bench side
   input  wire logic [2:0]             firePat,
   output logic [31:0]                 lastHold,
   // Block side
   output mlf_pkg::mlf_lock_type       lockEvt,
   input  wire mlf_pkg::mlf_stage_type stageCmd
);
   logic [31:0] holdCnt;   // Cycles out of run so far

   // ****************************************
   // Detector pulses
   // ****************************************
   // Flags follow the bench request, so a one cycle request is one pulse
   assign lockEvt = mlf_pkg::mlf_lock_type'(firePat);

   // ****************************************
   // Stage hold meter
   // ****************************************
   // Counts cycles out of run; keeps the length of the last interval
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         holdCnt  <= 32'h0;
         lastHold <= 32'h0;
      end else if (stageCmd !== mlf_pkg::STAGE_RUN) begin
         holdCnt <= holdCnt + 32'h1;
      end else if (holdCnt != 32'h0) begin
         lastHold <= holdCnt;
         holdCnt  <= 32'h0;
      end
   end
endmodule // mlf_stage_model

/* testbench/tb.sv */
// Purpose: Self-checking bench for the lock fault configuration block
// Assumes: Shortened millisecond count for simulation
// Notes:   Random settings from a fixed seed, every response code visited
`timescale 1ns/1ps
module tb;
   localparam int CPM = 10;          // Cycles per ms in simulation
   localparam int LIMIT = 80000;     // Cycle ceiling for the whole run
   logic          core_clk;          // 250 MHz clock
   logic          rst_b;             // Synchronous reset, active low
   logic [7:0]    regAddr;           // Register address
   logic [31:0]   regWdata;          // Register write data
   logic          regWr;             // Write strobe
   logic          regRd;             // Read strobe
   logic [31:0]   regRdata;          // Read data
   logic [2:0]    firePat;           // Detector pulse request
   logic [31:0]   lastHold;          // Length of last stage hold
   logic          lockReport;        // Report pulse
   logic          pinB;              // Fault pin, active low
   logic          irq;               // Interrupt level
   logic [31:0]   rd;                // Read result
   logic [31:0]   seed;              // Random seed
   int            badCount;          // Mismatches
   int            numChecks;         // Comparisons
   int            cyc;               // Cycle counter
   int            code, sel, det, n, expH;
   logic [2:0]    msk;               // Interrupt mask in use
   logic          rep;               // Report expected
   logic [31:0]   expS;              // Stage expected
   int            msTab [8] = '{100, 500, 1000, 2000, 3000, 5000, 7500,
                                10000};
   mlf_pkg::mlf_lock_type  lockEvt;  // Detector flags
   mlf_pkg::mlf_stage_type stageCmd; // Output stage command

   // ****************************************
   // Clock, design and partner
   // ****************************************
   always #2 core_clk = ~core_clk;

   mlf_lock_fault #(.CYC_PER_MS(CPM)) uut (.core_clk(core_clk),
      .rst_b(rst_b), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .lockEvt(lockEvt), .stageCmd(stageCmd),
      .faultIndicatorPin_b(pinB), .lockReport(lockReport), .irq(irq));

   mlf_stage_model model (.core_clk(core_clk), .rst_b(rst_b),
      .firePat(firePat), .lastHold(lastHold), .lockEvt(lockEvt),
      .stageCmd(stageCmd));

   // ****************************************
   // Tasks and functions
   // ****************************************
   // Compares one value and counts it
   task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
      numChecks++;
      if (seen !== exp) begin
         badCount++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One cycle write
   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge core_clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge core_clk);
      regWr <= 1'b0;
      #1;
   endtask

   // One cycle read, data taken in the following cycle
   task automatic rdReg(logic [7:0] a, output logic [31:0] d);
      @(posedge core_clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge core_clk);
      regRd <= 1'b0;
      #1 d = regRdata;
   endtask

   // One cycle detector pulse; answer visible after the return
   task automatic fire(logic [2:0] p);
      @(posedge core_clk);
      firePat <= p;
      @(posedge core_clk);
      firePat <= 3'h0;
      #1;
   endtask

   // Stage expected for a protective response code
   function automatic mlf_pkg::mlf_stage_type stageFor(int c);
      case (c % 4)
         0: return mlf_pkg::STAGE_TRISTATE;
         1: return mlf_pkg::STAGE_RECIRC;
         2: return mlf_pkg::STAGE_HS_BRAKE;
         default: return mlf_pkg::STAGE_LS_BRAKE;
      endcase
   endfunction

   // Prints counts and verdict, then stops
   task automatic printVerdict();
      $display("checks %0d mismatches %0d", numChecks, badCount);
      if (badCount == 0 && numChecks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Cuts a hang short
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == LIMIT) begin
         badCount++;
         printVerdict();
      end
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      core_clk = 1'b0;
      rst_b = 1'b0;
      regAddr = 8'h0;
      regWdata = 32'h0;
      regWr = 1'b0;
      regRd = 1'b0;
      firePat = 3'h0;
      seed = 32'h815B;
      badCount = 0;
      numChecks = 0;
      cyc = 0;
      repeat (5) @(posedge core_clk);
      rst_b <= 1'b1;
      // Reset values, unmapped read, full word storage
      rdReg(8'h90, rd);
      chk("one_rst", rd, 32'h0);
      rdReg(8'h94, rd);
      chk("two_rst", rd, 32'h0);
      rdReg(8'h10, rd);
      chk("unmapped", rd, 32'h0);
      n = $random(seed);
      wr(8'h94, n);
      rdReg(8'h94, rd);
      chk("two_rw", rd, n);
      // Each detector ignored while its enable is low
      wr(8'h90, 32'h40);
      for (int i = 0; i < 3; i++) begin
         wr(8'h94, {1'b0, 3'h7 & ~(3'h1 << i), 28'h0});
         fire(3'h1 << i);
         chk("en_off", lockReport, 0);
         fire(3'h1 << ((i + 1) % 3));
         chk("en_on", lockReport, 1);
      end
      wr(8'hA0, 32'h7);
      // Every response code with random detector, mask and delay
      for (code = 0; code < 16; code++) begin
         sel = $unsigned($random(seed)) % 2;
         det = $unsigned($random(seed)) % 3;
         msk = 3'($random(seed));
         wr(8'hA4, {29'h0, msk});
         rdReg(8'hA4, rd);
         chk("mask", rd, {29'h0, msk});
         wr(8'h90, {25'h0, code[3:0], sel[2:0]});
         n = $random(seed);
         wr(8'h94, {4'h7, n[27:0]});
         fire(3'h1 << det);
         rep = (code <= 8) || (code == 10);
         expS = (code < 8) ? stageFor(code) : 0;
         chk("report", lockReport, rep);
         chk("stage", stageCmd, expS);
         chk("irq", irq, rep && msk[det]);
         chk("pin", pinB, code > 3);
         if (code < 4) begin
            repeat (20) @(posedge core_clk);
            #1 chk("held", stageCmd, stageFor(code));
            chk("pin_held", pinB, 0);
            rdReg(8'hA8, rd);
            chk("state_lat", rd, 32'h20 | stageFor(code));
            wr(8'hAC, 32'h1);
            chk("cleared", stageCmd, 0);
            chk("pin_off", pinB, 1);
         end else if (code < 8) begin
            wr(8'hAC, 32'h1);
            chk("no_latch", stageCmd, stageFor(code));
            rdReg(8'hA8, rd);
            chk("state_rt", rd, 32'h10 | stageFor(code));
            expH = msTab[sel] * CPM;
            n = 0;
            while (stageCmd !== mlf_pkg::STAGE_RUN && n < expH + 50) begin
               @(posedge core_clk);
               #1 n++;
            end
            @(posedge core_clk);
            #1 chk("retry", (lastHold - expH + 2) <= 6, 1);
         end
         rdReg(8'hA0, rd);
         chk("status", rd, {29'h0, rep, 2'h0} >> (2 - det));
         wr(8'hA0, 32'h7);
         chk("irq_clr", irq, 0);
         rdReg(8'hA0, rd);
         chk("status_clr", rd, 0);
      end
      // Mid-run reset drops a latched fault and the settings
      wr(8'h94, 32'h7000_0000);
      wr(8'h90, 32'h0);
      fire(3'h1);
      chk("pre_rst", pinB, 0);
      @(posedge core_clk);
      rst_b <= 1'b0;
      repeat (5) @(posedge core_clk);
      rst_b <= 1'b1;
      #1 chk("rst_pin", pinB, 1);
      chk("rst_stage", stageCmd, 0);
      chk("rst_irq", irq, 0);
      rdReg(8'h94, rd);
      chk("rst_two", rd, 32'h0);
      rdReg(8'h90, rd);
      chk("rst_one", rd, 32'h0);
      printVerdict();
   end
endmodule // tb
